// ### dv/digital_port_access_logic_tb.sv
// Purpose: self-checking bench for the digital port access logic
// Assumes: one cpu access at a time, driven on the falling edge
// Notes:   pad levels come from pin_board_model
`timescale 1ns/1ps
module digital_port_access_logic_tb
  import port_access_pkg::*;
;
  logic        i_sys_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_clk_en = 1'b1;
  logic        i_acc_valid = 1'b0;
  op_t         i_op = OP_READ;
  logic        i_wide = 1'b0;
  logic [11:0] i_addr = 12'h0000;
  logic [1:0]  i_bit_sel = 2'h0;
  logic        i_use_l = 1'b0;
  logic [3:0]  i_l_reg = 4'h0;
  logic [7:0]  i_acc = 8'h00;
  logic        i_cy = 1'b0;
  logic        i_bank_enable_flag = 1'b0;
  logic [3:0]  i_bank_select_value = 4'h0;
  logic [39:0] ext = '0;
  logic [39:0] drv = '1;
  logic [39:0] pad;
  logic [39:0] o_pin_out;
  logic [39:0] o_pin_oe;
  logic [39:0] o_pullup_en;
  logic        o_rd_valid;
  logic        o_bit_data;
  logic        o_skip;
  logic        o_refused;
  logic [7:0]  o_rd_data;
  logic [7:0]  rd;
  logic        bt;
  logic        sk;
  logic        rf;
  logic        vd;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #20 i_sys_clk = ~i_sys_clk;

  digital_port_access_logic dut (
    .i_sys_clk, .i_reset_n, .i_clk_en, .i_acc_valid, .i_op,
    .i_wide, .i_addr, .i_bit_sel, .i_use_l, .i_l_reg, .i_acc, .i_cy,
    .i_bank_enable_flag, .i_bank_select_value, .o_rd_valid,
    .o_rd_data, .o_bit_data, .o_skip, .o_refused, .i_pin(pad),
    .o_pin_out, .o_pin_oe, .o_pullup_en
  );

  pin_board_model board (
    .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe),
    .i_pullup_en(o_pullup_en), .i_ext(ext), .i_ext_drv(drv),
    .o_pad(pad)
  );

  // ------------------------------------------------------------------
  // bench tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // request held over one rising edge, answer polled a few cycles
  task automatic acc(input op_t op, input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    @(negedge i_sys_clk);
    i_acc_valid = 1'b1;
    i_op = op;
    i_wide = w;
    i_addr = a;
    i_acc = d;
    @(negedge i_sys_clk);
    i_acc_valid = 1'b0;
    n = 0;
    while (o_rd_valid !== 1'b1 && o_refused !== 1'b1 && n < 4) begin
      @(negedge i_sys_clk);
      n++;
    end
    rd = o_rd_data;
    bt = o_bit_data;
    sk = o_skip;
    rf = o_refused;
    vd = o_rd_valid;
  endtask : acc

  task automatic bop(input op_t op, input logic [11:0] a,
                     input logic [1:0] b);
    i_bit_sel = b;
    acc(op, 1'b0, a, 8'h00);
  endtask : bop

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // ------------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    ext[15:12] = 4'hA;
    ext[11:8] = 4'h3;
    ext[27:24] = 4'h7;
    ext[7:4] = 4'hF;
    ext[39:32] = 8'h96;
    drv[7:4] = 4'h0;
    repeat (16) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    chk(o_pin_oe, '0);
    chk(o_pullup_en, '0);
    acc(OP_READ, 1'b1, ADDR_MODE_A, 8'h00);
    chk(rd, 8'h00);
    acc(OP_READ, 1'b1, ADDR_PU_A, 8'h00);
    chk(rd, 8'h00);
    acc(OP_READ, 1'b1, ADDR_PU_B, 8'h00);
    chk(rd, 8'h00);
    acc(OP_READ, 1'b0, 12'hFF4, 8'h00);
    chk(rf, 1'b1);
    done("reset");
    acc(OP_READ, 1'b0, 12'hFF3, 8'h00);
    chk(rd, 8'h0A);
    acc(OP_WRITE, 1'b0, 12'hFF3, 8'h05);
    chk(o_pin_oe[15:12], 4'h0);
    acc(OP_READ, 1'b0, 12'hFF3, 8'h00);
    chk(rd, 8'h0A);
    acc(OP_WRITE, 1'b1, ADDR_MODE_A, 8'h0F);
    chk({o_pin_oe[15:12], o_pin_out[15:12]}, 8'hF5);
    acc(OP_READ, 1'b0, 12'hFF3, 8'h00);
    chk(rd, 8'h05);
    done("port mode");
    acc(OP_READ, 1'b0, 12'hFF1, 8'h00);
    chk(rd, 8'h00);
    acc(OP_WRITE, 1'b1, ADDR_PU_A, 8'h4F);
    chk(o_pullup_en[27:0], 28'hF00_0FFE);
    acc(OP_READ, 1'b0, 12'hFF1, 8'h00);
    chk(rd, 8'h0F);
    acc(OP_WRITE, 1'b1, ADDR_MODE_A, 8'h0C);
    chk(o_pullup_en[15:12], 4'h3);
    acc(OP_WRITE, 1'b1, ADDR_PU_B, 8'h01);
    chk(o_pullup_en[39:32], 8'h0F);
    acc(OP_WRITE, 1'b1, ADDR_PU_B, 8'h00);
    chk(o_pullup_en[39:32], 8'h00);
    done("pull-up");
    acc(OP_XCH, 1'b0, 12'hFF2, 8'h09);
    chk({o_pin_oe[11:8], rd}, 12'h003);
    acc(OP_WRITE, 1'b1, ADDR_MODE_B, 8'h04);
    chk(o_pin_out[11:8], 4'h9);
    acc(OP_XCH, 1'b0, 12'hFF2, 8'h06);
    chk({rd, o_pin_out[11:8]}, 12'h096);
    done("exchange");
    acc(OP_INCREMENT_SKIP_OP, 1'b0, 12'hFF6, 8'h00);
    chk({o_pin_oe[27:24], rd}, 12'h008);
    acc(OP_WRITE, 1'b1, ADDR_MODE_A, 8'hF0);
    chk(o_pin_out[27:24], 4'h8);
    acc(OP_WRITE, 1'b0, 12'hFF6, 8'h0F);
    chk(o_pin_out[27:24], 4'hF);
    acc(OP_INCREMENT_SKIP_OP, 1'b0, 12'hFF6, 8'h00);
    chk({sk, rd[3:0], o_pin_out[27:24]}, 9'h100);
    done("increment");
    bop(OP_SET, 12'hFF6, 2'd2);
    chk(o_pin_out[27:24], 4'h4);
    i_cy = 1'b1;
    bop(OP_MOV1, 12'hFF6, 2'd0);
    chk(o_pin_out[27:24], 4'h5);
    bop(OP_CLR, 12'hFF6, 2'd2);
    chk(o_pin_out[27:24], 4'h1);
    bop(OP_TEST, 12'hFF6, 2'd0);
    chk(bt, 1'b1);
    bop(OP_TCLR, 12'hFF6, 2'd0);
    chk({sk, o_pin_out[27:24]}, 5'h10);
    i_use_l = 1'b1;
    i_l_reg = 4'hB;
    bop(OP_SET, 12'hFF4, 2'd0);
    chk(o_pin_out[27:24], 4'h8);
    i_use_l = 1'b0;
    // frozen enable: the write must not land
    i_clk_en = 1'b0;
    acc(OP_WRITE, 1'b0, 12'hFF6, 8'h03);
    chk({rf, o_pin_out[27:24]}, 5'h08);
    i_clk_en = 1'b1;
    done("bit ops");
    acc(OP_WRITE, 1'b1, ADDR_MODE_B, 8'h00);
    i_bank_enable_flag = 1'b1;
    bop(OP_SET, 12'hFF2, 2'd3);
    chk(rf, 1'b0);
    i_bank_enable_flag = 1'b0;
    acc(OP_WRITE, 1'b1, ADDR_MODE_B, 8'h04);
    chk(o_pin_out[11], 1'b1);
    done("input bit write");
    acc(OP_READ, 1'b1, 12'hFF8, 8'h00);
    chk(rd, 8'h96);
    acc(OP_WRITE, 1'b1, ADDR_MODE_C, 8'h03);
    acc(OP_WRITE, 1'b1, 12'hFF8, 8'hC3);
    chk({o_pin_oe[39:32], o_pin_out[39:32]}, 16'hFFC3);
    acc(OP_READ, 1'b1, 12'hFF8, 8'h00);
    chk(rd, 8'hC3);
    acc(OP_XCH, 1'b1, 12'hFF8, 8'h5A);
    chk({rd, o_pin_out[39:32]}, 16'hC35A);
    acc(OP_READ, 1'b1, 12'hFF9, 8'h00);
    chk(rf, 1'b1);
    done("byte pair");
    i_bank_enable_flag = 1'b1;
    acc(OP_READ, 1'b0, 12'hFF3, 8'h00);
    chk(rf, 1'b1);
    chk(vd, 1'b0);
    i_bank_select_value = 4'hF;
    acc(OP_READ, 1'b0, 12'hFF3, 8'h00);
    chk({rf, rd}, 9'h00A);
    chk(vd, 1'b1);
    done("bank gating");
    tally_and_finish();
  end
endmodule : digital_port_access_logic_tb

// ### dv/pin_board_model.sv
// Purpose: board side of the port pins, resolves every pad level
// Assumes: board sources are weak, the chip driver always wins
// Notes:   a floating pad shows the inverse of the board value
`timescale 1ns/1ps
module pin_board_model (
  // chip side
  input  wire logic [39:0] i_pin_out,
  input  wire logic [39:0] i_pin_oe,
  input  wire logic [39:0] i_pullup_en,
  // board side
  input  wire logic [39:0] i_ext,
  input  wire logic [39:0] i_ext_drv,
  output logic      [39:0] o_pad
);
  // ------------------------------------------------------------------
  // pad resolution
  // ------------------------------------------------------------------
  // inverse on a floating pad, so a stale value never reads as a match
  assign o_pad = (i_pin_oe & i_pin_out)
               | (~i_pin_oe & i_ext_drv & i_ext)
               | (~i_pin_oe & ~i_ext_drv & (i_pullup_en | ~i_ext));
endmodule : pin_board_model

// ### hw/digital_port_access_logic.sv
// Purpose: cpu-side access to the digital ports, mode and pull-up control
// Assumes: one access per enabled cycle, pins synchronous to the clock
// Notes:   answers one enabled edge after the access is taken
`timescale 1ns/1ps

// How it works
// R1 - ports 8 and 9 form one byte, port 8 in the low nibble
// R2 - byte and nibble accesses need bank flag clear or bank fifteen
// R3 - indirect bit access takes bit and two address bits from L
// R4 - input mode reads return live pin levels
// R5 - input mode writes update the latch only, driver stays off
// R6 - input mode exchange returns pins and latches the accumulator
// R7 - input mode increment latches pins plus one, driver stays off
// R8 - input mode bit writes set the bit, other latch bits undefined
// R9 - output mode reads return the latch, not the pins
// R10 - output mode writes update latch and drive pins at once
// R11 - output mode exchange swaps latch and accumulator, pins follow
// R12 - output mode increment adds one to the latch and drives it
// R13 - output mode bit write changes only the addressed bit
// R14 - pull-up on every pin but port zero lowest pin; the code gives port 5 no software pull-up, only the MASK_PU_P5 mask option
// R15 - software pull-up only connects while the pin is an input
// R16 - group A bits 0,1,2,3,6 serve ports 0,1,2,3,6
// R17 - group B bits 0 and 1 serve ports 8 and 9
// R18 - pull-up enable bit 0 disables, 1 enables
// R19 - software keeps pull-ups off on 8 and 9 as segment outputs
// R20 - mode bit 0 is input, 1 is output with buffer on
// R21 - reset clears all mode bits, every port an input
// R22 - reset clears both pull-up enable groups
module digital_port_access_logic
  import port_access_pkg::*;
#(
  parameter logic [3:0] MASK_PU_P5 = 4'h0
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  // cpu access
  input  wire logic        i_acc_valid,
  input  wire op_t         i_op,
  input  wire logic        i_wide,
  input  wire logic [11:0] i_addr,
  input  wire logic [1:0]  i_bit_sel,
  input  wire logic        i_use_l,
  input  wire logic [3:0]  i_l_reg,
  input  wire logic [7:0]  i_acc,
  input  wire logic        i_cy,
  input  wire logic        i_bank_enable_flag,
  input  wire logic [3:0]  i_bank_select_value,
  // cpu answer
  output logic             o_rd_valid,
  output logic      [7:0]  o_rd_data,
  output logic             o_bit_data,
  output logic             o_skip,
  output logic             o_refused,
  // pins
  input  wire logic [39:0] i_pin,
  output logic      [39:0] o_pin_out,
  output logic      [39:0] o_pin_oe,
  output logic      [39:0] o_pullup_en
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [39:0] latch_ff, nxt_latch;
  logic [7:0]  mode_a_ff, nxt_mode_a;
  logic [7:0]  mode_b_ff, nxt_mode_b;
  logic [7:0]  mode_c_ff, nxt_mode_c;
  logic [7:0]  pu_a_ff, nxt_pu_a;
  logic [7:0]  pu_b_ff, nxt_pu_b;
  logic        rd_valid_ff, nxt_rd_valid;
  logic [7:0]  rd_data_ff, nxt_rd_data;
  logic        bit_data_ff, nxt_bit_data;
  logic        skip_ff, nxt_skip;
  logic        refused_ff, nxt_refused;

  // decode helpers
  logic [11:0] addr;
  logic [1:0]  bsel;
  logic [3:0]  pidx;
  logic [5:0]  base, hb;
  logic        is_bit, bank_ok, port_ok, reg_hit, take;
  logic [39:0] mode_vec, nxt_mode_vec, eff;
  logic [9:0]  pu_grp, nxt_pu_grp;
  logic [7:0]  eff8, pin8, lat8, mode8, new8, reg_rd;
  logic [3:0]  nib;

  // mode vector as seen by every pin, pull-up enables per port
  function automatic logic [39:0] modes(input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] c);
    logic [39:0] m;
    m        = '0;
    m[12+:4] = a[3:0];
    m[24+:4] = a[7:4];
    m[8+:4]  = {NIB_W{b[MB_PORT2]}};
    m[20+:4] = {NIB_W{b[MB_PORT5]}};
    m[32+:4] = {NIB_W{c[MB_PORT8]}};
    m[36+:4] = {NIB_W{c[MB_PORT9]}};
    return m;
  endfunction : modes

  function automatic logic [9:0] pugrp(input logic [7:0] a,
      input logic [7:0] b);
    logic [9:0] g;
    g    = '0;
    g[0] = a[PA_PORT0];  // [R16]
    g[1] = a[PA_PORT1];
    g[2] = a[PA_PORT2];
    g[3] = a[PA_PORT3];
    g[6] = a[PA_PORT6];
    g[8] = b[PB_PORT8];  // [R17]
    g[9] = b[PB_PORT9];
    return g;
  endfunction : pugrp

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  always_comb begin
    addr = i_use_l ? {i_addr[11:2], i_l_reg[3:2]} : i_addr;  // [R3]
    bsel = i_use_l ? i_l_reg[1:0] : i_bit_sel;               // [R3]
    pidx = addr[3:0];
    base = {pidx, 2'b00};
    hb   = i_wide ? 6'(base + NIB_STEP) : base;
    is_bit = (i_op inside {OP_SET, OP_CLR, OP_MOV1, OP_TCLR, OP_TEST});
    // bit addressing ignores the bank, byte and nibble do not
    bank_ok = !i_bank_enable_flag
              || (i_bank_select_value == BANK_IO);             // [R2]
    port_ok = (addr[11:4] == IO_PAGE) && (pidx < 4'(NUM_PORTS))
              && PORT_EXISTS[pidx]
              && (!i_wide || (pidx == PAIR_LO && !is_bit));    // [R1]
    reg_hit = i_wide && !is_bit
              && (addr inside {ADDR_MODE_A, ADDR_MODE_B, ADDR_MODE_C,
                               ADDR_PU_A, ADDR_PU_B});
    take = i_acc_valid
           && (is_bit ? port_ok : bank_ok && (port_ok || reg_hit));
    mode_vec = modes(mode_a_ff, mode_b_ff, mode_c_ff);
    pu_grp   = pugrp(pu_a_ff, pu_b_ff);
    // bus sees pins in input mode, latch in output mode, per bit
    eff   = (mode_vec & latch_ff) | (~mode_vec & i_pin);       // [R4][R9]
    eff8  = {eff[hb+:4], eff[base+:4]};                        // [R1]
    pin8  = {i_pin[hb+:4], i_pin[base+:4]};
    lat8  = {latch_ff[hb+:4], latch_ff[base+:4]};
    mode8 = {mode_vec[hb+:4], mode_vec[base+:4]};
    case (addr)
      ADDR_MODE_A: reg_rd = mode_a_ff;
      ADDR_MODE_B: reg_rd = mode_b_ff;
      ADDR_MODE_C: reg_rd = mode_c_ff;
      ADDR_PU_A:   reg_rd = pu_a_ff;
      ADDR_PU_B:   reg_rd = pu_b_ff;
      default:     reg_rd = '0;
    endcase
  end

  // ------------------------------------------------------------------
  // access execution
  // ------------------------------------------------------------------
  always_comb begin
    nxt_latch    = latch_ff;
    nxt_mode_a   = mode_a_ff;
    nxt_mode_b   = mode_b_ff;
    nxt_mode_c   = mode_c_ff;
    nxt_pu_a     = pu_a_ff;
    nxt_pu_b     = pu_b_ff;
    nxt_rd_valid = take;
    nxt_refused  = i_acc_valid && !take;
    nxt_rd_data  = '0;
    nxt_bit_data = 1'b0;
    nxt_skip     = 1'b0;
    new8         = lat8;
    nib          = eff8[3:0];
    if (take && reg_hit) begin
      nxt_rd_data = reg_rd;
      if (i_op == OP_WRITE) begin
        case (addr)
          ADDR_MODE_A: nxt_mode_a = i_acc;  // [R20]
          ADDR_MODE_B: nxt_mode_b = i_acc;
          ADDR_MODE_C: nxt_mode_c = i_acc;
          ADDR_PU_A:   nxt_pu_a = i_acc;    // [R18]
          ADDR_PU_B:   nxt_pu_b = i_acc;    // [R18]
          default:     nxt_rd_data = reg_rd;
        endcase
      end
    end else if (take) begin
      case (i_op)
        OP_READ: begin
          nxt_rd_data = i_wide ? eff8 : {4'h0, eff8[3:0]};  // [R4][R9]
        end
        OP_WRITE: begin
          new8 = i_acc;  // [R5][R10]
        end
        OP_XCH: begin
          // input: pins to acc; output: latch to acc; both are eff
          nxt_rd_data = i_wide ? eff8 : {4'h0, eff8[3:0]};  // [R6][R11]
          new8        = i_acc;                              // [R6][R11]
        end
        OP_INCREMENT_SKIP_OP: begin
          nib         = eff8[3:0] + NIB_ONE;  // [R7][R12]
          new8        = {lat8[7:4], nib};
          nxt_rd_data = {4'h0, nib};
          nxt_skip    = (nib == 4'h0);
        end
        OP_TEST: begin
          nxt_bit_data = eff8[bsel];  // [R4][R9]
        end
        default: begin
          // bit writes: unaddressed bits take what the bus sees,
          // the latch in output mode, the pins in input mode
          new8 = {lat8[7:4], eff8[3:0]};             // [R8][R13]
          nxt_bit_data = eff8[bsel];
          case (i_op)
            OP_SET:  new8[bsel] = 1'b1;
            OP_CLR:  new8[bsel] = 1'b0;
            OP_MOV1: new8[bsel] = i_cy;
            OP_TCLR: begin
              new8[bsel] = 1'b0;
              nxt_skip   = eff8[bsel];
            end
            default: new8[bsel] = lat8[bsel];
          endcase
        end
      endcase
      nxt_latch[base+:4] = new8[3:0];
      if (i_wide) begin
        nxt_latch[hb+:4] = new8[7:4];  // [R1]
      end
    end
    nxt_mode_vec = modes(nxt_mode_a, nxt_mode_b, nxt_mode_c);
    nxt_pu_grp   = pugrp(nxt_pu_a, nxt_pu_b);
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      latch_ff    <= '0;
      mode_a_ff   <= REG_RST;  // [R21]
      mode_b_ff   <= REG_RST;  // [R21]
      mode_c_ff   <= REG_RST;  // [R21]
      pu_a_ff     <= REG_RST;  // [R22]
      pu_b_ff     <= REG_RST;  // [R22]
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
      bit_data_ff <= 1'b0;
      skip_ff     <= 1'b0;
      refused_ff  <= 1'b0;
    end else if (i_clk_en) begin
      latch_ff    <= nxt_latch;
      mode_a_ff   <= nxt_mode_a;
      mode_b_ff   <= nxt_mode_b;
      mode_c_ff   <= nxt_mode_c;
      pu_a_ff     <= nxt_pu_a;
      pu_b_ff     <= nxt_pu_b;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff  <= nxt_rd_data;
      bit_data_ff <= nxt_bit_data;
      skip_ff     <= nxt_skip;
      refused_ff  <= nxt_refused;
    end
  end

  assign o_rd_valid = rd_valid_ff;
  assign o_rd_data  = rd_data_ff;
  assign o_bit_data = bit_data_ff;
  assign o_skip     = skip_ff;
  assign o_refused  = refused_ff;

  // ------------------------------------------------------------------
  // pin cells; unmapped slots never drive or pull
  // ------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [3:0] ALLOW = !PORT_EXISTS[p] ? 4'h0 :
                                   (p == 0) ? PU_ALLOW_P0 : PU_ALLOW_ALL;
    port_pin_cell #(
      .PU_ALLOW (ALLOW),                                   // [R14]
      .MASK_PU  ((p == 5) ? MASK_PU_P5 : 4'h0)
    ) u_cell (
      .i_sys_clk   (i_sys_clk),
      .i_reset_n   (i_reset_n),
      .i_clk_en    (i_clk_en),
      .i_nxt_latch (nxt_latch[4*p+:4]),
      .i_nxt_mode  (nxt_mode_vec[4*p+:4]),
      .i_nxt_pu_en (nxt_pu_grp[p]),
      .o_pin_out   (o_pin_out[4*p+:4]),
      .o_pin_oe    (o_pin_oe[4*p+:4]),
      .o_pullup_en (o_pullup_en[4*p+:4])
    );
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence nib_req(op_t op);
    i_clk_en && take && !reg_hit && !i_wide && i_op == op;
  endsequence

  bank_gate_a: assert property (i_clk_en && i_acc_valid && !is_bit // [R2]
      && i_bank_enable_flag && i_bank_select_value != BANK_IO
      |=> !o_rd_valid && o_refused)
    else $error("access outside bank fifteen was decoded");

  pair_read_a: assert property (i_clk_en && take && !reg_hit // [R1]
      && i_wide && i_op == OP_READ && mode8 == 8'h00
      |=> o_rd_data == $past(pin8))
    else $error("paired read not port8 low, port9 high");

  pin_read_a: assert property (nib_req(OP_READ) ##0 // [R4]
      mode8[3:0] == 4'h0 |=> o_rd_data[3:0] == $past(pin8[3:0]))
    else $error("input mode read did not return pins");

  latch_read_a: assert property (nib_req(OP_READ) ##0 // [R9]
      mode8[3:0] == 4'hF |=> o_rd_data[3:0] == $past(lat8[3:0]))
    else $error("output mode read did not return latch");

  oe_mode_a: assert property (o_pin_oe == mode_vec) // [R20]
    else $error("output enable differs from mode bits");

  pin_latch_a: assert property (o_pin_out == latch_ff) // [R10]
    else $error("pins do not follow the latch at once");

  xch_swap_a: assert property (nib_req(OP_XCH) // [R6]
      |=> o_rd_data[3:0] == $past(eff8[3:0])
          && latch_ff[$past(base)+:4] == $past(i_acc[3:0]))
    else $error("exchange did not swap data");

  increment_skip_op_a: assert property (nib_req(OP_INCREMENT_SKIP_OP) // [R7]
      |=> o_rd_data[3:0] == 4'($past(eff8[3:0]) + NIB_ONE))
    else $error("increment result wrong");

  pu_off_out_a: assert property // [R15]
      ((o_pullup_en & o_pin_oe & ~{16'h0000, MASK_PU_P5, 20'h0_0000})
       == '0)
    else $error("pull-up connected on an output pin");

  pu_map_a: assert property (!o_pullup_en[0] // [R14]
      && o_pullup_en[7:4] == {4{pu_a_ff[PA_PORT1]}})
    else $error("pull-up group map wrong");

endmodule : digital_port_access_logic

// ### hw/port_pin_cell.sv
// Purpose: per-port pin driver, output enable and pull-up control
// Assumes: fed with next-state latch and mode so pins move with them
// Notes:   mask pull-ups stay on regardless of mode
`timescale 1ns/1ps
module port_pin_cell
  import port_access_pkg::*;
#(
  parameter logic [3:0] PU_ALLOW = 4'hF,
  parameter logic [3:0] MASK_PU  = 4'h0
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  // next state from the access logic
  input  wire logic [3:0] i_nxt_latch,
  input  wire logic [3:0] i_nxt_mode,
  input  wire logic       i_nxt_pu_en,
  // pin side
  output logic      [3:0] o_pin_out,
  output logic      [3:0] o_pin_oe,
  output logic      [3:0] o_pullup_en
);

  logic [3:0] nxt_pu;

  // ------------------------------------------------------------------
  // software pull-up only on pins that are not driving
  // ------------------------------------------------------------------
  always_comb begin
    nxt_pu = ({NIB_W{i_nxt_pu_en}} & ~i_nxt_mode & PU_ALLOW)  // [R15][R18]
             | MASK_PU;                                        // [R14]
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pin_out   <= '0;
      o_pin_oe    <= '0;
      o_pullup_en <= '0;
    end else if (i_clk_en) begin
      o_pin_out   <= i_nxt_latch;
      o_pin_oe    <= i_nxt_mode;  // [R20]
      o_pullup_en <= nxt_pu;
    end
  end

endmodule : port_pin_cell

// ### pkg/port_access_pkg.sv
// Purpose: shared constants and types for the digital port access logic
// Assumes: ten 4-bit port slots, addressed in the top data memory page
// Notes:   slots 4 and 7 have no port behind them
package port_access_pkg;

  // ------------------------------------------------------------------
  // geometry and decode
  // ------------------------------------------------------------------
  localparam int        NUM_PORTS   = 10;
  localparam int        NIB_W       = 4;
  localparam logic [7:0] IO_PAGE    = 8'hFF;
  localparam logic [3:0] BANK_IO    = 4'hF;
  localparam logic [3:0] PAIR_LO    = 4'h8;
  localparam logic [9:0] PORT_EXISTS = 10'h36F;
  localparam logic [3:0] NIB_ONE    = 4'h1;
  localparam logic [5:0] NIB_STEP   = 6'h04;

  // ------------------------------------------------------------------
  // mode and pull-up control registers (byte wide, top page)
  // ------------------------------------------------------------------
  localparam logic [11:0] ADDR_MODE_A = 12'hFE8;
  localparam logic [11:0] ADDR_MODE_B = 12'hFEC;
  localparam logic [11:0] ADDR_MODE_C = 12'hFEE;
  localparam logic [11:0] ADDR_PU_A   = 12'hFDC;
  localparam logic [11:0] ADDR_PU_B   = 12'hFDE;
  localparam logic [7:0]  REG_RST     = 8'h00;

  // mode group bit positions for nibble-wide ports
  localparam int MB_PORT2 = 2;
  localparam int MB_PORT5 = 5;
  localparam int MB_PORT8 = 0;
  localparam int MB_PORT9 = 1;

  // pull-up group bit positions
  localparam int PA_PORT0 = 0;
  localparam int PA_PORT1 = 1;
  localparam int PA_PORT2 = 2;
  localparam int PA_PORT3 = 3;
  localparam int PA_PORT6 = 6;
  localparam int PB_PORT8 = 0;
  localparam int PB_PORT9 = 1;

  // port 0 lowest pin never takes a software pull-up
  localparam logic [3:0] PU_ALLOW_P0 = 4'hE;
  localparam logic [3:0] PU_ALLOW_ALL = 4'hF;

  // ------------------------------------------------------------------
  // access operations from the cpu
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ  = 4'h0,  // load, test, arithmetic, compare
    OP_WRITE = 4'h1,  // transfer accumulator to port
    OP_XCH   = 4'h2,  // exchange_op
    OP_INCREMENT_SKIP_OP  = 4'h3,  // increment_skip_op
    OP_SET   = 4'h4,
    OP_CLR   = 4'h5,
    OP_MOV1  = 4'h6,  // carry to bit
    OP_TCLR  = 4'h7,  // test_and_clear_op
    OP_TEST  = 4'h8   // bit test or bit load
  } op_t;

endpackage : port_access_pkg
